// ==== wtc_pkg.sv ====
// wtc_pkg: constants and carrier types of the wake-up timer counting core
package wtc_pkg;

    // ==================================================
    // register byte addresses
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_ENABLE = 5'h04;
    localparam logic [4:0] ADDR_MC_LO  = 5'h08;
    localparam logic [4:0] ADDR_MC_HI  = 5'h0C;
    localparam logic [4:0] ADDR_CNT_LO = 5'h10;
    localparam logic [4:0] ADDR_CNT_HI = 5'h14;

    // ==================================================
    // reset values
    localparam logic [15:0] RST_CTRL  = 16'h0000;
    localparam logic [15:0] RST_MC_LO = 16'h3FFF;
    localparam logic [15:0] RST_MC_HI = 16'h0000;
    localparam logic [31:0] CNT_ZERO  = 32'h0000_0000;
    localparam logic [31:0] CNT_FULL  = 32'hFFFF_FFFF;

    // ==================================================
    // control field positions
    localparam int CTL_PRESC_LSB = 0;
    localparam int CTL_DIR_BIT   = 2;
    localparam int CTL_FRZ_BIT   = 3;
    localparam int CTL_MODE_BIT  = 4;
    localparam int CTL_SYSCK_BIT = 5;
    localparam int CTL_WIDTH     = 6;

    // ==================================================
    // prescaler codes and divide figures
    localparam logic [1:0] PRESC_DIV1  = 2'h0;
    localparam logic [1:0] PRESC_DIV16 = 2'h1;
    localparam int         DIV_ONE     = 1;
    localparam int         DIV_SYSCK   = 4;
    localparam int         DIV_SIXTEEN = 16;
    localparam int         PRE_W       = 16;

    // ==================================================
    // carriers
    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } wtc_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } wtc_avs_rsp_s;

endpackage

// ==== wtc_core.sv ====
// wtc_core: wake-up timer counting core with an avalon-mm register slave
module wtc_core
#(
    parameter int DIV_CODE2 = 64,    // divide for prescaler code 10
    parameter int DIV_CODE3 = 256    // divide for prescaler code 11
) (
    input  wire logic                  clk,      // 20 mhz clock
    input  wire logic                  sys_rst,  // synchronous reset, active high
    input  wire wtc_pkg::wtc_avs_req_s avs_req,  // avalon-mm request
    output wire wtc_pkg::wtc_avs_rsp_s avs_rsp   // avalon-mm answer
);
    import wtc_pkg::*;

    typedef struct packed {
        logic [CTL_WIDTH-1:0] ctrl;
        logic                 en;
        logic [15:0]          mc_lo;
        logic [15:0]          mc_hi;
        logic [31:0]          cnt;
        logic [PRE_W-1:0]     pre;
        logic [15:0]          hi_latch;
        logic                 frozen;
        logic                 wait_n;
        logic [31:0]          rdata;
    } wtc_state_s;

    wtc_state_s st_ff;
    wtc_state_s nxt_st;

    // ==================================================
    // helpers
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        lane_merge = old;
        if (be[0]) begin
            lane_merge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            lane_merge[15:8] = wd[15:8];
        end
    endfunction

    function automatic logic [PRE_W-1:0] presc_last(input logic [1:0] code,
                                                    input logic       sysck);
        int d;
        d = DIV_ONE;
        case (code)
            PRESC_DIV1:  d = sysck ? DIV_SYSCK : DIV_ONE;
            PRESC_DIV16: d = DIV_SIXTEEN;
            2'h2:        d = DIV_CODE2;
            default:     d = DIV_CODE3;
        endcase
        presc_last = PRE_W'(d - 1);
    endfunction

    // ==================================================
    // decoded controls
    logic        dir_down;
    logic        free_run;
    logic        freeze_on;
    logic [31:0] match_c;
    logic        tick;
    logic        accept;
    logic        rd_acc;
    logic        wr_acc;

    assign dir_down  = st_ff.ctrl[CTL_DIR_BIT];
    assign free_run  = st_ff.ctrl[CTL_MODE_BIT];
    assign freeze_on = st_ff.ctrl[CTL_FRZ_BIT];
    assign match_c   = {st_ff.mc_hi, st_ff.mc_lo};
    // at-or-past compare: a divide change mid-count cannot strand the counter
    assign tick      = st_ff.en &&
                       (st_ff.pre >= presc_last(st_ff.ctrl[CTL_PRESC_LSB +: 2],
                                                st_ff.ctrl[CTL_SYSCK_BIT]));
    // every request is taken once, on the edge where waitrequest drops
    assign accept    = (avs_req.read || avs_req.write) && st_ff.wait_n;
    assign rd_acc    = accept && avs_req.read;
    assign wr_acc    = accept && avs_req.write;

    // ==================================================
    // next state
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.wait_n = !accept;

        // counting
        if (!st_ff.en) begin
            nxt_st.pre = '0;
            nxt_st.cnt = dir_down ? CNT_FULL : CNT_ZERO;
        end else if (tick) begin
            nxt_st.pre = '0;
            if (!dir_down) begin
                if (!free_run && st_ff.cnt == match_c) begin
                    nxt_st.cnt = CNT_ZERO;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
                end
            end else begin
                if (!free_run && st_ff.cnt == match_c) begin
                    nxt_st.cnt = CNT_FULL;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
                end
            end
        end else begin
            nxt_st.pre = st_ff.pre + {{(PRE_W-1){1'b0}}, 1'b1};
        end

        // register reads
        if (rd_acc) begin
            nxt_st.rdata = '0;
            case (avs_req.address)
                ADDR_CTRL:   nxt_st.rdata = 32'(st_ff.ctrl);
                ADDR_ENABLE: nxt_st.rdata = 32'(st_ff.en);
                ADDR_MC_LO:  nxt_st.rdata = 32'(st_ff.mc_lo);
                ADDR_MC_HI:  nxt_st.rdata = 32'(st_ff.mc_hi);
                ADDR_CNT_LO: begin
                    nxt_st.rdata = 32'(st_ff.cnt[15:0]);
                    if (freeze_on) begin
                        nxt_st.hi_latch = st_ff.cnt[31:16];
                        nxt_st.frozen   = 1'b1;
                    end
                end
                ADDR_CNT_HI: begin
                    nxt_st.rdata  = 32'(st_ff.frozen ? st_ff.hi_latch
                                                     : st_ff.cnt[31:16]);
                    nxt_st.frozen = 1'b0;
                end
                default:     nxt_st.rdata = '0;
            endcase
        end

        // register writes; unmapped addresses are answered and ignored
        if (wr_acc) begin
            case (avs_req.address)
                ADDR_CTRL: begin
                    nxt_st.ctrl = CTL_WIDTH'(lane_merge(16'(st_ff.ctrl),
                                                        avs_req.writedata,
                                                        avs_req.byteenable));
                end
                ADDR_ENABLE: begin
                    if (avs_req.byteenable[0]) begin
                        nxt_st.en = avs_req.writedata[0];
                    end
                end
                ADDR_MC_LO: begin
                    nxt_st.mc_lo = lane_merge(st_ff.mc_lo, avs_req.writedata,
                                              avs_req.byteenable);
                end
                ADDR_MC_HI: begin
                    nxt_st.mc_hi = lane_merge(st_ff.mc_hi, avs_req.writedata,
                                              avs_req.byteenable);
                end
                default: begin
                    nxt_st.ctrl = st_ff.ctrl;
                end
            endcase
        end

        // disabled timer or freeze off leaves no latch behind
        if (!st_ff.en || !freeze_on) begin
            if (!(rd_acc && avs_req.address == ADDR_CNT_LO && freeze_on)) begin
                nxt_st.frozen = 1'b0;
            end
        end
    end

    // ==================================================
    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff.ctrl     <= CTL_WIDTH'(RST_CTRL);
            st_ff.en       <= 1'b0;
            st_ff.mc_lo    <= RST_MC_LO;
            st_ff.mc_hi    <= RST_MC_HI;
            st_ff.cnt      <= CNT_ZERO;
            st_ff.pre      <= '0;
            st_ff.hi_latch <= '0;
            st_ff.frozen   <= 1'b0;
            st_ff.wait_n   <= 1'b1;
            st_ff.rdata    <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // one driver for the whole answer struct
    assign avs_rsp = '{readdata: st_ff.rdata, waitrequest: st_ff.wait_n};

    // ==================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_up_periodic_wrap: assert property (
        st_ff.en && tick && !dir_down && !free_run && st_ff.cnt == match_c
        |=> st_ff.cnt == CNT_ZERO)
        else $error("periodic up count did not return to zero");

    chk_down_periodic_reload: assert property (
        st_ff.en && tick && dir_down && !free_run && st_ff.cnt == match_c
        |=> st_ff.cnt == CNT_FULL)
        else $error("periodic down count did not reload full scale");

    chk_free_up_wrap: assert property (
        st_ff.en && tick && !dir_down && free_run
        |=> st_ff.cnt == $past(st_ff.cnt) + 32'h0000_0001)
        else $error("free-running up count did not step by one");

    // the 32-bit step carries the wrap at either end as well
    chk_free_down_wrap: assert property (
        st_ff.en && tick && dir_down && free_run
        |=> st_ff.cnt == $past(st_ff.cnt) - 32'h0000_0001)
        else $error("free-running down count did not step or wrap");

    chk_up_periodic_step: assert property (
        st_ff.en && tick && !dir_down && !free_run && st_ff.cnt != match_c
        |=> st_ff.cnt == $past(st_ff.cnt) + 32'h0000_0001)
        else $error("periodic up count did not step by one");

    chk_down_periodic_step: assert property (
        st_ff.en && tick && dir_down && !free_run && st_ff.cnt != match_c
        |=> st_ff.cnt == $past(st_ff.cnt) - 32'h0000_0001)
        else $error("periodic down count did not step by one");

    chk_freeze_latch_hi: assert property (
        rd_acc && avs_req.address == ADDR_CNT_LO && freeze_on && st_ff.en
        |=> st_ff.frozen && st_ff.hi_latch == $past(st_ff.cnt[31:16]))
        else $error("low half read did not latch high half");

    chk_freeze_release: assert property (
        rd_acc && avs_req.address == ADDR_CNT_HI && st_ff.frozen
        |=> !st_ff.frozen && st_ff.rdata[15:0] == $past(st_ff.hi_latch))
        else $error("high half read did not release the latch");

    chk_nofreeze_live: assert property (
        rd_acc && avs_req.address == ADDR_CNT_HI && !st_ff.frozen
        |=> st_ff.rdata == 32'($past(st_ff.cnt[31:16])))
        else $error("high half read without latch was not live");

    chk_disabled_hold: assert property (
        !st_ff.en ##1 !st_ff.en
        |-> st_ff.cnt == ($past(dir_down) ? CNT_FULL : CNT_ZERO))
        else $error("disabled timer left its reset value");

    chk_presc_sixteen: assert property (
        tick && st_ff.ctrl[CTL_PRESC_LSB +: 2] == PRESC_DIV16 && !wr_acc
        |=> !tick [*8])
        else $error("divide-by-16 ticked too early");

    chk_wait_one_cycle: assert property (
        accept |=> !st_ff.wait_n ##1 st_ff.wait_n)
        else $error("waitrequest low for other than one cycle");

    chk_presc_sysck_four: assert property (
        tick && st_ff.ctrl[CTL_PRESC_LSB +: 2] == PRESC_DIV1
        && st_ff.ctrl[CTL_SYSCK_BIT] && !wr_acc
        |=> !tick [*3])
        else $error("system-clock divide-by-4 ticked too early");

    chk_lo_half_live: assert property (
        rd_acc && avs_req.address == ADDR_CNT_LO
        |=> st_ff.rdata == 32'($past(st_ff.cnt[15:0])))
        else $error("low half read did not return live count bits");

    chk_read_upper_zero: assert property (
        rd_acc |=> st_ff.rdata[31:16] == 16'h0000)
        else $error("read data carried bits above the register");

    chk_disabled_prescale: assert property (
        !st_ff.en |=> st_ff.pre == '0)
        else $error("disabled timer let its prescaler run");

    chk_wait_idle_high: assert property (
        !accept |=> st_ff.wait_n)
        else $error("waitrequest dropped without a request");

    cov_periodic_up: cover property (
        tick && !dir_down && !free_run && st_ff.cnt == match_c);
    cov_free_down_wrap: cover property (
        tick && dir_down && free_run && st_ff.cnt == CNT_ZERO);
    cov_freeze_pair: cover property (
        st_ff.frozen ##[1:50] !st_ff.frozen);
    cov_periodic_down: cover property (
        tick && dir_down && !free_run && st_ff.cnt == match_c);
    cov_presc_sixteen: cover property (
        tick && st_ff.ctrl[CTL_PRESC_LSB +: 2] == PRESC_DIV16);

endmodule

// ==== wakeup_timer_count_control_test.sv ====
// wakeup_timer_count_control_test: self-checking bench for the wake-up timer counting core
module wakeup_timer_count_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import wtc_pkg::*;

    logic         clk;         // 20 mhz clock
    logic         sys_rst;     // synchronous reset
    wtc_avs_req_s avs_req;     // bus request
    wtc_avs_rsp_s avs_rsp;     // bus answer
    int           num_errors;  // mismatches
    int           checked;     // comparisons
    int           cycles;      // run length

    wtc_core dut (
        .clk     (clk),
        .sys_rst (sys_rst),
        .avs_req (avs_req),
        .avs_rsp (avs_rsp)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==================================================
    // shared tasks
    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic expect16(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // values are sampled before the edge's updates land, so no race with the slave
    task automatic bus(input logic [4:0] a, input logic wr_n_rd, input logic [15:0] d,
                       output logic [31:0] q);
        avs_req.address    <= a;
        avs_req.read       <= ~wr_n_rd;
        avs_req.write      <= wr_n_rd;
        avs_req.writedata  <= {16'h0000, d};
        avs_req.byteenable <= 4'hF;
        // no limit of its own: a missing answer runs into the run timeout
        do begin
            @(posedge clk);
        end while (avs_rsp.waitrequest !== 1'b0);
        q = avs_rsp.readdata;
        avs_req.read  <= 1'b0;
        avs_req.write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        logic [31:0] q;
        bus(a, 1'b0, 16'h0000, q);
        v = q[15:0];
    endtask

    // config is only legal with the timer stopped
    task automatic restart(input logic [15:0] ctrl, input logic [15:0] mlo,
                           input logic [15:0] mhi);
        wr(ADDR_ENABLE, 16'h0000);
        wr(ADDR_MC_LO, mlo);
        wr(ADDR_MC_HI, mhi);
        wr(ADDR_CTRL, ctrl);
    endtask

    // ==================================================
    // scenarios
    task automatic test_reset_values();
        logic [15:0] v;
        rd(ADDR_CTRL, v);
        expect16(v, RST_CTRL, "ctrl reset");
        rd(ADDR_ENABLE, v);
        expect16(v, 16'h0000, "enable reset");
        rd(ADDR_MC_LO, v);
        expect16(v, RST_MC_LO, "match lo reset");
        rd(ADDR_MC_HI, v);
        expect16(v, RST_MC_HI, "match hi reset");
        rd(ADDR_CNT_LO, v);
        expect16(v, 16'h0000, "count lo reset");
        rd(ADDR_CNT_HI, v);
        expect16(v, 16'h0000, "count hi reset");
        wr(5'h18, 16'hFFFF);
        rd(5'h18, v);
        expect16(v, 16'h0000, "unmapped read");
        wr(ADDR_CNT_LO, 16'h1234);
        rd(ADDR_CNT_LO, v);
        expect16(v, 16'h0000, "count write ignored");
        wr(ADDR_CTRL, 16'h002B);
        rd(ADDR_CTRL, v);
        expect16(v, 16'h002B, "ctrl readback");
        wr(ADDR_CTRL, 16'h0000);
    endtask

    // back-to-back reads sit three cycles apart, so the count moves three per read
    task automatic test_sequence(input logic [15:0] ctrl, input logic [15:0] mlo,
                                 input logic [15:0] mhi, input int period);
        logic [15:0] v;
        logic [15:0] start;
        logic [15:0] want;
        int          prev;
        int          e;
        start = ctrl[CTL_DIR_BIT] ? 16'hFFFF : 16'h0000;
        restart(ctrl, mlo, mhi);
        rd(ADDR_CNT_LO, v);
        expect16(v, start, "held count lo");
        rd(ADDR_CNT_HI, v);
        expect16(v, start, "held count hi");
        wr(ADDR_ENABLE, 16'h0001);
        rd(ADDR_CNT_LO, v);
        prev = ctrl[CTL_DIR_BIT] ? int'(16'hFFFF - v) : int'(v);
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_CNT_LO, v);
            e = (period > 0) ? (prev + 3) % period : prev + 3;
            want = ctrl[CTL_DIR_BIT] ? 16'hFFFF - 16'(e) : 16'(e);
            expect16(v, want, "count step");
            prev = e;
        end
        rd(ADDR_CNT_HI, v);
        expect16(v, start, "live count hi");
    endtask

    task automatic test_rate(input logic [15:0] ctrl, input int div);
        logic [15:0] a;
        logic [15:0] b;
        restart(ctrl, RST_MC_LO, RST_MC_HI);
        wr(ADDR_ENABLE, 16'h0001);
        rd(ADDR_CNT_LO, a);
        repeat (10 * div - 3) @(posedge clk);
        rd(ADDR_CNT_LO, b);
        expect16(b - a, 16'd10, "prescaled steps");
    endtask

    // one crossing of the low half costs 65536 cycles, so it is done once
    task automatic test_freeze();
        logic [15:0] v;
        restart(16'h0018, RST_MC_LO, RST_MC_HI);
        wr(ADDR_ENABLE, 16'h0001);
        repeat (65500) @(posedge clk);
        rd(ADDR_CNT_LO, v);
        checked++;
        if (v < 16'd65480 || v > 16'd65530) begin
            num_errors++;
            $display("unexpected at %0t: snapshot lo %h", $time, v);
        end
        repeat (40) @(posedge clk);
        rd(ADDR_CNT_HI, v);
        expect16(v, 16'h0000, "frozen hi");
        rd(ADDR_CNT_HI, v);
        expect16(v, 16'h0001, "released hi");
    endtask

    // ==================================================
    // run control
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles >= 90000) begin
                num_errors++;
                $display("unexpected at %0t: run timed out", $time);
                give_verdict();
            end
        end
    end

    initial begin
        avs_req    = '0;
        sys_rst    = 1'b1;
        num_errors = 0;
        checked    = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        test_reset_values();
        test_sequence(16'h0000, 16'h0005, 16'h0000, 6);
        test_sequence(16'h0004, 16'hFFFA, 16'hFFFF, 6);
        test_sequence(16'h0010, 16'h0005, 16'h0000, 0);
        test_sequence(16'h0014, 16'hFFFA, 16'hFFFF, 0);
        test_rate(16'h0010, DIV_ONE);
        test_rate(16'h0030, DIV_SYSCK);
        test_rate(16'h0011, DIV_SIXTEEN);
        test_rate(16'h0012, 64);
        test_rate(16'h0013, 256);
        test_freeze();
        give_verdict();
    end
endmodule
